/* File: nvm_ctrl_defines.vh */
`ifndef NVM_CTRL_DEFINES_VH
`define NVM_CTRL_DEFINES_VH
// register byte addresses
`define OFS_ACCESS_CONTROL   12'h000
`define OFS_UNLOCK_PORT      12'h004
`define OFS_DATA_REG         12'h008
`define OFS_ADDR_REG         12'h00C
`define OFS_TABLE_POINTER_LOW       12'h010
`define OFS_TABLE_POINTER_HIGH      12'h014
`define OFS_TABLE_POINTER_UPPER     12'h018
`define OFS_TABLE_LATCH      12'h01C
`define OFS_IRQ_FLAGS_TWO    12'h020
`define OFS_IRQ_ENABLES_TWO  12'h024
`define OFS_RESET_CAUSE      12'h028
// access control fields
`define BIT_MEMORY_SELECT    7
`define BIT_CONFIG_SELECT    6
`define BIT_ROW_ERASE        4
`define BIT_WRITE_ERROR      3
`define BIT_WRITE_ENABLE     2
`define BIT_WRITE_START      1
`define BIT_READ_START       0
// flag register field
`define BIT_WRITE_COMPLETE   4
// flag register implemented bits
`define IRQ_FLAGS_MASK       8'hD5
// unlock keys
`define UNLOCK_KEY_FIRST     8'h55
`define UNLOCK_KEY_SECOND    8'hAA
// reset values
`define RST_BYTE             8'h00
// self-timed write
`define WRITE_TIME_US        4
`define CLK_MHZ              100
`define WRITE_CYCLES         (`WRITE_TIME_US * `CLK_MHZ)
`endif

/* File: nvm_byte_array.v */
module nvm_byte_array #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          clk,
  input  wire          ce,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire          re,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      if (re) begin
        rdata <= mem[raddr];
      end
    end
  end
endmodule // nvm_byte_array

/* File: write_timer.v */
module write_timer #(
  parameter CYCLES = 400,
  parameter CW     = 16
) (
  input  wire clk,
  input  wire arst_n,
  input  wire ce,
  input  wire start,
  input  wire abort,
  output wire busy,
  output reg  done
);
  // the start edge is the first busy cycle, so load one less
  localparam [31:0] LOAD_FULL = CYCLES - 1;
  reg [CW-1:0] cnt_r;

  assign busy = (cnt_r != {CW{1'b0}});

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= {CW{1'b0}};
      done  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (abort) begin
        cnt_r <= {CW{1'b0}};
      end else if (start) begin
        cnt_r <= LOAD_FULL[CW-1:0];
      end else if (busy) begin
        cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule // write_timer

/* File: eeprom_flash_access_ctrl.v */
// Notes on behaviour
// - data memory: 256 bytes, 8-bit address 00h..FFh, single-byte read and write
// - byte write erases then programs; duration set by on-chip timer
// - unlock port has no storage, reads zero, takes only unlock writes
// - bit 7 memory select: 0 data eeprom, 1 program flash
// - bit 6 config select steers to config registers; else memory select chooses
// - bit 2 write enable gates cycles; write start cannot be set while clear
// - clearing write enable never aborts a running cycle
// - bit 3 write error set when master clear or watchdog cuts a cycle
// - on write error memory select and row erase are kept
// - reset clears data and address; firmware reloads them before retry
// - bit 1 write start begins a self-timed cycle, reads 0 when done
// - read and write start: software sets only, hardware clears
// - bit 0 read start does a one-cycle read, then clears
// - read start cannot be set while memory select is 1
// - bit 4 row erase makes next flash cycle erase the row, clears on that cycle's completion
// - write complete flag set on finish, only software clears it
// - table pointer from upper (21:16), high (15:8) and low (7:0) bytes
// - cycle starts only after 55h then AAh to unlock port, then write start
// - write enable and write start set together start no cycle
// - during a cycle control, address and data ignore writes
// - read byte in data register next cycle, held until next read or write
//
// The APB slave port and the register addresses are this design's own decisions.
`include "nvm_ctrl_defines.vh"
module eeprom_flash_access_ctrl #(
  parameter WRITE_CYCLES = `WRITE_CYCLES,
  parameter TIMER_W      = 16
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        ce,
  input  wire        write_abort_reset,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  output wire        flash_erase_pulse,
  output wire        flash_write_pulse,
  output wire        config_write_pulse,
  output wire [21:0] table_pointer,
  output wire        write_busy
);
  reg  [7:0]  data_r;
  reg  [7:0]  addr_r;
  reg         mem_sel_r;
  reg         cfg_sel_r;
  reg         row_erase_r;
  reg         wr_err_r;
  reg         wr_en_r;
  reg         wr_start_r;
  reg         rd_start_r;
  reg  [7:0]  tbl_low_r;
  reg  [7:0]  tbl_high_r;
  reg  [5:0]  tbl_upper_r;
  reg  [7:0]  tbl_latch_r;
  reg  [7:0]  irq_flags_r;
  reg  [7:0]  irq_en_r;
  reg         rd_pend_r;
  reg         op_mem_r;
  reg         op_cfg_r;
  reg         op_erase_r;
  reg         abort_s1_r;
  reg         abort_s2_r;
  reg         abort_s3_r;

  // unlock sequence states
  localparam [2:0] UL_IDLE  = 3'b001;
  localparam [2:0] UL_FIRST = 3'b010;
  localparam [2:0] UL_ARMED = 3'b100;
  reg  [2:0]  ul_state_r;
  reg  [2:0]  ul_state_nxt;

  wire        acc      = psel & penable & ce;
  wire        wr_acc   = acc & pwrite;
  wire        rd_acc   = acc & ~pwrite;
  wire        hit_ctl  = (paddr == `OFS_ACCESS_CONTROL);
  wire        hit_ul   = (paddr == `OFS_UNLOCK_PORT);
  wire        hit_dat  = (paddr == `OFS_DATA_REG);
  wire        hit_adr  = (paddr == `OFS_ADDR_REG);
  wire        hit_tl   = (paddr == `OFS_TABLE_POINTER_LOW);
  wire        hit_th   = (paddr == `OFS_TABLE_POINTER_HIGH);
  wire        hit_tu   = (paddr == `OFS_TABLE_POINTER_UPPER);
  wire        hit_lat  = (paddr == `OFS_TABLE_LATCH);
  wire        hit_irf  = (paddr == `OFS_IRQ_FLAGS_TWO);
  wire        hit_ire  = (paddr == `OFS_IRQ_ENABLES_TWO);
  wire        hit_rc   = (paddr == `OFS_RESET_CAUSE);
  wire        mapped   = hit_ctl | hit_ul | hit_dat | hit_adr | hit_tl | hit_th | hit_tu
                         | hit_lat | hit_irf | hit_ire | hit_rc;
  wire        busy;
  wire        done;
  wire        abort_seen = abort_s2_r & abort_s3_r;
  // a cut cycle must also stop the timer, or a late completion would still land
  wire        abort_cut  = abort_seen & wr_start_r;
  wire        ctl_wr   = wr_acc & hit_ctl & ~busy & ~wr_start_r;
  // write start only from armed unlock, prior write enable, not set together
  wire        start_go = ctl_wr & pwdata[`BIT_WRITE_START] & wr_en_r
                         & (ul_state_r == UL_ARMED);
  // read start refused while flash selected
  wire        rd_go    = ctl_wr & pwdata[`BIT_READ_START]
                         & ~pwdata[`BIT_MEMORY_SELECT];
  wire        eep_op   = ~op_mem_r & ~op_cfg_r;
  wire [7:0]  ctl_view = {mem_sel_r, cfg_sel_r, 1'b0, row_erase_r, wr_err_r, wr_en_r,
                          wr_start_r, rd_start_r};
  wire [7:0]  ee_rdata;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign table_pointer = {tbl_upper_r, tbl_high_r, tbl_low_r};
  assign write_busy    = wr_start_r;
  assign flash_erase_pulse  = done & op_mem_r & ~op_cfg_r & op_erase_r;
  assign flash_write_pulse  = done & op_mem_r & ~op_cfg_r & ~op_erase_r;
  assign config_write_pulse = done & op_cfg_r;

  write_timer #(
    .CYCLES (WRITE_CYCLES),
    .CW     (TIMER_W)
  ) u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .start  (start_go),
    .abort  (abort_cut),
    .busy   (busy),
    .done   (done)
  );

  // erase-then-program lands in the array on completion
  nvm_byte_array #(
    .AW (8),
    .DW (8)
  ) u_array (
    .clk   (clk),
    .ce    (ce),
    .we    (done & eep_op),
    .waddr (addr_r),
    .wdata (data_r),
    .re    (rd_go),
    .raddr (addr_r),
    .rdata (ee_rdata)
  );

  // unlock tracker: a wrong key to the port or a write to any other register breaks the sequence; reads do not
  always @* begin
    ul_state_nxt = ul_state_r;
    if (wr_acc & hit_ul) begin
      case (ul_state_r)
        UL_IDLE:  ul_state_nxt = (pwdata[7:0] == `UNLOCK_KEY_FIRST) ? UL_FIRST : UL_IDLE;
        UL_FIRST: ul_state_nxt = (pwdata[7:0] == `UNLOCK_KEY_SECOND) ? UL_ARMED : UL_IDLE;
        UL_ARMED: ul_state_nxt = (pwdata[7:0] == `UNLOCK_KEY_FIRST) ? UL_FIRST : UL_IDLE;
        default:  ul_state_nxt = UL_IDLE;
      endcase
    end else if (wr_acc) begin
      ul_state_nxt = UL_IDLE;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ul_state_r <= UL_IDLE;
    end else if (ce) begin
      ul_state_r <= ul_state_nxt;
    end
  end

  // abort reset arrives from the reset controller, async to us
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      abort_s1_r <= 1'b0;
      abort_s2_r <= 1'b0;
      abort_s3_r <= 1'b0;
    end else if (ce) begin
      abort_s1_r <= write_abort_reset;
      abort_s2_r <= abort_s1_r;
      abort_s3_r <= abort_s2_r;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_r      <= `RST_BYTE;
      addr_r      <= `RST_BYTE;
      mem_sel_r   <= 1'b0;
      cfg_sel_r   <= 1'b0;
      row_erase_r <= 1'b0;
      wr_err_r    <= 1'b0;
      wr_en_r     <= 1'b0;
      wr_start_r  <= 1'b0;
      rd_start_r  <= 1'b0;
      rd_pend_r   <= 1'b0;
      op_mem_r    <= 1'b0;
      op_cfg_r    <= 1'b0;
      op_erase_r  <= 1'b0;
      tbl_low_r   <= `RST_BYTE;
      tbl_high_r  <= `RST_BYTE;
      tbl_upper_r <= 6'h00;
      tbl_latch_r <= `RST_BYTE;
      irq_flags_r <= `RST_BYTE;
      irq_en_r    <= `RST_BYTE;
    end else if (ce) begin
      rd_pend_r  <= rd_go;
      rd_start_r <= rd_go;
      if (abort_cut) begin
        // warm reset mid-cycle: flag it, keep select and row erase
        wr_err_r   <= 1'b1;
        wr_start_r <= 1'b0;
        wr_en_r    <= 1'b0;
        data_r     <= `RST_BYTE;
        addr_r     <= `RST_BYTE;
      end else begin
        if (ctl_wr) begin
          mem_sel_r   <= pwdata[`BIT_MEMORY_SELECT];
          cfg_sel_r   <= pwdata[`BIT_CONFIG_SELECT];
          row_erase_r <= pwdata[`BIT_ROW_ERASE];
          wr_err_r    <= pwdata[`BIT_WRITE_ERROR];
          wr_en_r     <= pwdata[`BIT_WRITE_ENABLE];
        end
        if (start_go) begin
          wr_start_r <= 1'b1;
          op_mem_r   <= mem_sel_r;
          op_cfg_r   <= cfg_sel_r;
          op_erase_r <= row_erase_r;
        end else if (done) begin
          wr_start_r <= 1'b0;
          if (op_erase_r & op_mem_r & ~op_cfg_r) begin
            row_erase_r <= 1'b0;
          end
        end
        if (rd_pend_r) begin
          data_r <= ee_rdata;
        end else if (wr_acc & hit_dat & ~wr_start_r) begin
          data_r <= pwdata[7:0];
        end
        if (wr_acc & hit_adr & ~wr_start_r) begin
          addr_r <= pwdata[7:0];
        end
      end
      if (wr_acc & hit_tl) begin
        tbl_low_r <= pwdata[7:0];
      end
      if (wr_acc & hit_th) begin
        tbl_high_r <= pwdata[7:0];
      end
      if (wr_acc & hit_tu) begin
        tbl_upper_r <= pwdata[5:0];
      end
      if (wr_acc & hit_lat) begin
        tbl_latch_r <= pwdata[7:0];
      end
      if (wr_acc & hit_ire) begin
        irq_en_r <= pwdata[7:0] & `IRQ_FLAGS_MASK;
      end
      // completion wins over a same-cycle software clear
      if (wr_acc & hit_irf) begin
        irq_flags_r <= (pwdata[7:0] & `IRQ_FLAGS_MASK)
                       | ({7'h00, done} << `BIT_WRITE_COMPLETE);
      end else if (done) begin
        irq_flags_r[`BIT_WRITE_COMPLETE] <= 1'b1;
      end
    end
  end

  // read data registered on the setup phase, ready in the access phase
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (ce & psel & ~penable & ~pwrite) begin
      case (paddr)
        `OFS_ACCESS_CONTROL:  prdata <= {24'h000000, ctl_view};
        `OFS_UNLOCK_PORT:     prdata <= 32'h00000000;
        `OFS_DATA_REG:        prdata <= {24'h000000, data_r};
        `OFS_ADDR_REG:        prdata <= {24'h000000, addr_r};
        `OFS_TABLE_POINTER_LOW:      prdata <= {24'h000000, tbl_low_r};
        `OFS_TABLE_POINTER_HIGH:     prdata <= {24'h000000, tbl_high_r};
        `OFS_TABLE_POINTER_UPPER:    prdata <= {26'h0, tbl_upper_r};
        `OFS_TABLE_LATCH:     prdata <= {24'h000000, tbl_latch_r};
        `OFS_IRQ_FLAGS_TWO:   prdata <= {24'h000000, irq_flags_r};
        `OFS_IRQ_ENABLES_TWO: prdata <= {24'h000000, irq_en_r};
        `OFS_RESET_CAUSE:     prdata <= {31'h0, wr_err_r};
        default:              prdata <= 32'h00000000;
      endcase
    end
  end

  wire unused_rd = rd_acc;
endmodule // eeprom_flash_access_ctrl

/* File: eeprom_flash_access_ctrl_chk.sv */
module nvm_ctrl_chk #(
  parameter WRITE_CYCLES = 16
) (
  input wire        clk,
  input wire        arst_n,
  input wire        ce,
  input wire        write_abort_reset,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        flash_erase_pulse,
  input wire        flash_write_pulse,
  input wire        config_write_pulse,
  input wire [21:0] table_pointer,
  input wire        write_busy
);
  reg  [7:0] cnt_r;
  reg        ab_r;
  wire       rq = psel & penable & ce;
  wire       pl = flash_erase_pulse | flash_write_pulse | config_write_pulse;
  // busy length, and whether an abort cut it short
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 8'h00;
      ab_r  <= 1'b0;
    end else begin
      cnt_r <= write_busy ? cnt_r + 8'h01 : 8'h00;
      ab_r  <= write_abort_reset | (write_busy & ab_r);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_unlock_reads_zero: assert property (rq && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
    else $error("unlock port read not zero");
  a_write_full_count: assert property ($fell(write_busy) && !ab_r |-> cnt_r == WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_start_after_write: assert property ($rose(write_busy) |->
    $past(rq && pwrite && paddr == 12'h000 && pwdata[1])) else $error("cycle began unasked");
  a_pulse_one_cycle: assert property (pl |=> !pl)
    else $error("completion pulse too long");
  a_unmapped_err: assert property (rq && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h028))
    else $error("slave error wrong");
  a_table_pointer_low: assert property (rq && pwrite && paddr == 12'h010
    |=> table_pointer[7:0] == $past(pwdata[7:0])) else $error("pointer low wrong");
  a_table_pointer_upper: assert property (rq && pwrite && paddr == 12'h018
    |=> table_pointer[21:16] == $past(pwdata[5:0])) else $error("pointer upper wrong");
  a_abort_ends: assert property (write_busy && write_abort_reset |-> ##[1:8] !write_busy)
    else $error("abort did not end cycle");
endmodule // nvm_ctrl_chk

bind eeprom_flash_access_ctrl nvm_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .clk, .arst_n, .ce, .write_abort_reset, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pslverr, .flash_erase_pulse, .flash_write_pulse, .config_write_pulse,
  .table_pointer, .write_busy);

/* File: test_eeprom_flash_access_ctrl.sv */
module test_eeprom_flash_access_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        write_abort_reset = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  wire         pready, pslverr, flash_erase_pulse, flash_write_pulse, config_write_pulse;
  wire  [31:0] prdata;
  wire  [21:0] table_pointer;
  wire         write_busy;
  int          mismatches = 0;
  int          n_tests = 0;
  eeprom_flash_access_ctrl #(.WRITE_CYCLES(16)) dut_u (
    .clk, .arst_n, .ce, .write_abort_reset, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pready, .prdata, .pslverr, .flash_erase_pulse, .flash_write_pulse,
    .config_write_pulse, .table_pointer, .write_busy);
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask
  task automatic go(input logic [7:0] m);
    wr(12'h000, m);
    wr(12'h004, 8'h55);
    wr(12'h004, 8'hAA);
    wr(12'h000, m | 8'h02);
  endtask
  // watch completion pulses over a span longer than one write cycle
  task automatic settle(output logic [2:0] p);
    p = 3'b000;
    repeat (30) begin
      @(posedge clk);
      p = p | {flash_erase_pulse, flash_write_pulse, config_write_pulse};
    end
  endtask
  task automatic t_reset();
    for (int a = 0; a < 11; a++) rd(12'(a * 4), 8'h00);
    rd(12'h0FC, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_data();
    logic [2:0] p;
    wr(12'h00C, 8'hFF);
    wr(12'h008, 8'h5A);
    go(8'h04);
    rd(12'h000, 8'h06);
    settle(p);
    chk(32'(p), 32'h0);
    rd(12'h000, 8'h04);
    rd(12'h020, 8'h10);
    wr(12'h020, 8'h00);
    rd(12'h020, 8'h00);
    wr(12'h008, 8'h00);
    wr(12'h000, 8'h01);
    rd(12'h000, 8'h00);
    rd(12'h008, 8'h5A);
    wr(12'h000, 8'h81);
    rd(12'h000, 8'h80);
    $display("data write and read done");
  endtask
  task automatic t_guard();
    logic [31:0] cs [4] = '{32'h0055AA02, 32'h0055AA06, 32'h04AA5506, 32'h04550006};
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, cs[i][31:24]);
      wr(12'h004, cs[i][23:16]);
      wr(12'h004, cs[i][15:8]);
      wr(12'h000, cs[i][7:0]);
      rd(12'h000, cs[i][7:0] & 8'hFD);
    end
    $display("start guards done");
  endtask
  task automatic t_busy();
    logic [2:0] p;
    wr(12'h00C, 8'h00);
    wr(12'h008, 8'h11);
    go(8'h04);
    wr(12'h000, 8'h00);
    wr(12'h008, 8'h22);
    wr(12'h00C, 8'h20);
    rd(12'h000, 8'h06);
    settle(p);
    rd(12'h008, 8'h11);
    rd(12'h00C, 8'h00);
    wr(12'h000, 8'h01);
    rd(12'h008, 8'h11);
    $display("busy lockout done");
  endtask
  task automatic t_targets();
    logic [2:0]  p;
    logic [23:0] tg [3] = '{24'h848402, 24'h948404, 24'hC4C401};
    for (int i = 0; i < 3; i++) begin
      go(tg[i][23:16]);
      settle(p);
      chk(32'(p), 32'(tg[i][2:0]));
      rd(12'h000, tg[i][15:8]);
    end
    wr(12'h000, 8'h00);
    $display("targets done");
  endtask
  task automatic t_tbl();
    wr(12'h010, 8'hA5);
    wr(12'h014, 8'h3C);
    wr(12'h018, 8'hFF);
    rd(12'h018, 8'h3F);
    chk(32'(table_pointer), 32'h003F3CA5);
    $display("table pointer done");
  endtask
  // writes while the clock enable is low are lost
  task automatic t_freeze();
    ce <= 1'b0;
    wr(12'h010, 8'h11);
    ce <= 1'b1;
    rd(12'h010, 8'hA5);
    chk(32'(table_pointer), 32'h003F3CA5);
    $display("clock enable freeze done");
  endtask
  task automatic t_mid_reset();
    wr(12'h00C, 8'h5C);
    wr(12'h008, 8'hC5);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(12'h008, 8'h00);
    rd(12'h00C, 8'h00);
    rd(12'h010, 8'h00);
    $display("mid-run reset done");
  endtask
  task automatic t_abort();
    wr(12'h00C, 8'h33);
    wr(12'h008, 8'h77);
    go(8'h94);
    write_abort_reset <= 1'b1;
    repeat (8) @(posedge clk);
    write_abort_reset <= 1'b0;
    rd(12'h000, 8'h98);
    rd(12'h008, 8'h00);
    rd(12'h00C, 8'h00);
    rd(12'h028, 8'h01);
    wr(12'h000, 8'h00);
    $display("abort done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_data();
    t_guard();
    t_busy();
    t_targets();
    t_tbl();
    t_freeze();
    t_abort();
    t_mid_reset();
    stop_test();
  end
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule // test_eeprom_flash_access_ctrl
